// file: shared/mss_map.vh
`ifndef MSS_MAP_VH
`define MSS_MAP_VH

// ----------------------------------------
// widths and counts
// ----------------------------------------
`define MSS_AW          6
`define MSS_DW          16
`define MSS_NPRESET     16
`define MSS_NTERM       8
`define MSS_FW          8

// ----------------------------------------
// register addresses (word index)
// ----------------------------------------
`define MSS_A_PRESET0   6'h00
`define MSS_A_PRESET15  6'h0f
`define MSS_A_SOURCE    6'h10
`define MSS_A_METHOD    6'h11
`define MSS_A_MAXFREQ   6'h12
`define MSS_A_OUTSET    6'h13
`define MSS_A_EDITVAL   6'h14
`define MSS_A_EDITIDX   6'h15
`define MSS_A_STORE     6'h16
`define MSS_A_STATUS    6'h17
`define MSS_A_TARGET    6'h18
`define MSS_A_TFUNC1    6'h20
`define MSS_A_TFUNC8    6'h27

// ----------------------------------------
// field positions
// ----------------------------------------
`define MSS_ST_OVR      0
`define MSS_ST_ASSIGN   1
`define MSS_ST_PEND     2
`define MSS_ST_IDX_LO   4
`define MSS_STORE_GO    0

// ----------------------------------------
// codes
// ----------------------------------------
`define MSS_SRC_TERM    2'h1
`define MSS_METH_BIN    2'h0
`define MSS_FN_SEL0     8'h02
`define MSS_FN_SEL1     8'h03
`define MSS_FN_SEL2     8'h04
`define MSS_FN_SEL3     8'h05

// ----------------------------------------
// reset values
// ----------------------------------------
`define MSS_RST_SOURCE  2'h1
`define MSS_RST_METHOD  2'h0
`define MSS_RST_MAXFREQ 16'h1388
`define MSS_RST_OUTSET  16'h0000
`define MSS_RST_PRESET  16'h0000
`define MSS_RST_TFUNC   64'h0000_0000_0000_0000
`define MSS_RST_DATA    16'h0000

`endif

// file: verification/mss_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"

module mss_chk
(
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  rst,
    // register port
    input wire logic [`MSS_AW-1:0]    reg_addr,
    input wire logic [`MSS_DW-1:0]    reg_wdata,
    input wire logic                  reg_wr,
    input wire logic                  reg_rd,
    input wire logic [`MSS_DW-1:0]    reg_rdata,
    // terminals and outputs
    input wire logic [`MSS_NTERM-1:0] term_in,
    input wire logic [`MSS_DW-1:0]    term_ref,
    input wire logic [`MSS_DW-1:0]    freq_target,
    input wire logic                  override_active,
    input wire logic [3:0]            sel_index
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // read port
    // ----------------------------------------
    rdata_idle_a: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    target_read_a: assert property (
        reg_rd && reg_addr == `MSS_A_TARGET |=>
        reg_rdata == $past(freq_target))
        else $error("target read differs from target output");
    status_read_a: assert property (
        reg_rd && reg_addr == `MSS_A_STATUS |=>
        reg_rdata[0] == $past(override_active) &&
        reg_rdata[7:4] == $past(sel_index) && reg_rdata[15:8] == 8'h00)
        else $error("status read differs from outputs");

    // ----------------------------------------
    // select decode
    // ----------------------------------------
    ovr_nonzero_a: assert property (
        override_active |-> sel_index != 4'h0)
        else $error("override with zero index");
    idx_cause_a: assert property (
        $changed(sel_index) |-> $past(term_in, 3) != $past(term_in, 4) ||
        $past(reg_wr) || $past(reg_wr, 2))
        else $error("index changed without a cause");
    rise_together_a: assert property (
        $rose(override_active) && !$past(reg_wr) && !$past(reg_wr, 2)
        |-> $changed(sel_index))
        else $error("override rose apart from index");
    fall_zero_a: assert property (
        $fell(override_active) && !$past(reg_wr) && !$past(reg_wr, 2)
        |-> sel_index == 4'h0)
        else $error("override fell with nonzero index");
    hold_target_a: assert property (
        override_active && $past(override_active) && $stable(sel_index) &&
        !$past(reg_wr) && !$past(reg_wr, 2) |-> $stable(freq_target))
        else $error("target moved under steady override");
endmodule // mss_chk

bind mss_top mss_chk mss_chk_inst
(
    .mclk            (mclk),
    .rst             (rst),
    .reg_addr        (reg_addr),
    .reg_wdata       (reg_wdata),
    .reg_wr          (reg_wr),
    .reg_rd          (reg_rd),
    .reg_rdata       (reg_rdata),
    .term_in         (term_in),
    .term_ref        (term_ref),
    .freq_target     (freq_target),
    .override_active (override_active),
    .sel_index       (sel_index)
);
`default_nettype wire

// file: verification/mss_switch_model.sv
`timescale 1ns/1ps
`default_nettype none

module mss_switch_model
(
    // clock
    input wire logic         mclk,
    // commanded switch positions
    input wire logic [7:0]   want_term,
    input wire logic [15:0]  want_ref,
    // terminal side
    output var logic [7:0]   term_in,
    output var logic [15:0]  term_ref
);
    // switches idle open, reference at zero
    initial
    begin
        term_in = 8'h00;
        term_ref = 16'h0000;
    end

    // switches move just after an edge, unrelated to the sync stages
    always @(posedge mclk)
    begin
        term_in <= want_term;
        term_ref <= want_ref;
    end
endmodule // mss_switch_model
`default_nettype wire

// file: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"

module testbench;
    logic        mclk, rst, reg_wr, reg_rd, override_active;
    logic [5:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, freq_target, want_ref, term_ref, rd_val;
    logic [7:0]  want_term, term_in;
    logic [3:0]  sel_index;
    int          mismatches, n_tests;
    int          cycles = 0;

    mss_top mss_top_inst (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .term_in(term_in), .term_ref(term_ref),
        .freq_target(freq_target), .override_active(override_active),
        .sel_index(sel_index));
    mss_switch_model mss_switch_model_inst (.mclk(mclk),
        .want_term(want_term), .want_ref(want_ref), .term_in(term_in),
        .term_ref(term_ref));

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task results;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // hang guard, run needs well under two thousand cycles
    always @(posedge mclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            mismatches++;
            results;
        end
    end

    // ----------------------------------------
    // register bus and switches
    // ----------------------------------------
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task rchk(input logic [5:0] a, input logic [15:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
        chk($sformatf("reg %h", a), rd_val, exp);
    endtask

    task store(input logic [3:0] i, input logic [15:0] v);
        wr(`MSS_A_EDITIDX, {12'h000, i});
        wr(`MSS_A_EDITVAL, v);
        wr(`MSS_A_STORE, 16'h0001);
    endtask

    // one edge in the model, three in the design
    task apply(input logic [7:0] t);
        @(posedge mclk);
        want_term <= t;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // select bits sit on terminals 8, 5, 3 and 1
    function automatic logic [7:0] tmap(input logic [3:0] i);
        return {i[0], 2'b00, i[1], 1'b0, i[2], 1'b0, i[3]};
    endfunction

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        reg_addr = 6'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        want_term = 8'h00;
        want_ref = 16'h0777;
        mismatches = 0;
        n_tests = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        rchk(`MSS_A_SOURCE, 16'h0001);
        rchk(`MSS_A_METHOD, 16'h0000);
        rchk(`MSS_A_MAXFREQ, 16'h1388);
        rchk(`MSS_A_TFUNC8, 16'h0000);
        rchk(6'h3f, 16'h0000);
        for (int i = 0; i < 16; i++)
            store(4'(i), {4'h0, 4'(i), 8'h55});
        for (int i = 0; i < 16; i++)
            rchk(6'(i), {4'h0, 4'(i), 8'h55});
        // edit dropped by a new index, read-only preset write
        wr(`MSS_A_EDITIDX, 16'h0003);
        wr(`MSS_A_EDITVAL, 16'h0abc);
        rchk(`MSS_A_STATUS, 16'h0004);
        wr(`MSS_A_EDITIDX, 16'h0004);
        wr(`MSS_A_STORE, 16'h0001);
        wr(6'h05, 16'h0bad);
        rchk(6'h03, 16'h0355);
        rchk(6'h04, 16'h0455);
        rchk(6'h05, 16'h0555);
        // no select function assigned: reference passes
        apply(8'hff);
        chk("ovr none", {15'h0000, override_active}, 16'h0000);
        chk("tgt none", freq_target, 16'h0777);
        // only the low bit assigned, on the last terminal
        wr(`MSS_A_TFUNC8, {8'h00, `MSS_FN_SEL0});
        apply(8'hff);
        chk("idx low", {12'h000, sel_index}, 16'h0001);
        chk("tgt low", freq_target, 16'h0155);
        wr(`MSS_A_TFUNC1, {8'h00, `MSS_FN_SEL3});
        wr(`MSS_A_TFUNC1 + 6'h04, {8'h00, `MSS_FN_SEL1});
        wr(`MSS_A_TFUNC1 + 6'h02, {8'h00, `MSS_FN_SEL2});
        for (int i = 0; i < 16; i++)
        begin
            apply(tmap(4'(i)));
            chk("idx", {12'h000, sel_index}, 16'(i));
            chk("ovr", {15'h0000, override_active}, 16'(i != 0));
            chk("tgt", freq_target,
                (i == 0) ? 16'h0777 : {4'h0, 4'(i), 8'h55});
        end
        // keypad source: no override, keypad setting used
        apply(tmap(4'h9));
        wr(`MSS_A_OUTSET, 16'h0abc);
        wr(`MSS_A_SOURCE, 16'h0000);
        repeat (2) @(posedge mclk);
        #1;
        chk("ovr src", {15'h0000, override_active}, 16'h0000);
        chk("tgt src", freq_target, 16'h0abc);
        wr(`MSS_A_SOURCE, 16'h0001);
        // non-binary method: no override, reference used
        wr(`MSS_A_METHOD, 16'h0001);
        repeat (2) @(posedge mclk);
        #1;
        chk("ovr meth", {15'h0000, override_active}, 16'h0000);
        chk("tgt meth", freq_target, 16'h0777);
        wr(`MSS_A_METHOD, 16'h0000);
        // limit raised before a high preset is stored
        wr(`MSS_A_MAXFREQ, 16'h3000);
        store(4'h9, 16'h2000);
        repeat (2) @(posedge mclk);
        #1;
        chk("tgt high", freq_target, 16'h2000);
        rchk(`MSS_A_STATUS, 16'h0093);
        rchk(`MSS_A_TARGET, 16'h2000);
        // limit lowered under a high preset: target held at limit
        wr(`MSS_A_MAXFREQ, 16'h1800);
        repeat (2) @(posedge mclk);
        #1;
        chk("tgt clamp", freq_target, 16'h1800);
        results;
    end
endmodule // testbench
`default_nettype wire

// file: verilog/mss_preset_store.v
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"

// sixteen preset frequencies in flip-flops
module mss_preset_store
(
    // clock and reset
    input  wire                 mclk,
    input  wire                 rst,
    // commit port
    input  wire                 we,
    input  wire [3:0]           widx,
    input  wire [`MSS_DW-1:0]   wdata,
    // read ports
    input  wire [3:0]           ridx_a,
    output wire [`MSS_DW-1:0]   rdata_a,
    input  wire [3:0]           ridx_b,
    output wire [`MSS_DW-1:0]   rdata_b
);

    reg [`MSS_DW-1:0] mem_reg [0:`MSS_NPRESET-1];
    integer i;

    // commit only on a store pulse
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < `MSS_NPRESET; i = i + 1)
                mem_reg[i] <= `MSS_RST_PRESET;
        end
        else if (we)
            mem_reg[widx] <= wdata;
    end

    // bus view and speed lookup
    assign rdata_a = mem_reg[ridx_a];
    assign rdata_b = mem_reg[ridx_b];

endmodule // mss_preset_store

`default_nettype wire

// file: verilog/mss_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"

// two-stage synchroniser for the terminal inputs
module mss_sync
(
    // clock and reset
    input  wire                 mclk,
    input  wire                 rst,
    // terminals
    input  wire [`MSS_NTERM-1:0] d_in,
    output reg  [`MSS_NTERM-1:0] d_out
);

    reg [`MSS_NTERM-1:0] meta_reg;

    // first stage feeds only the second
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            meta_reg <= {`MSS_NTERM{1'b0}};
            d_out    <= {`MSS_NTERM{1'b0}};
        end
        else
        begin
            meta_reg <= d_in;
            d_out    <= meta_reg;
        end
    end

endmodule // mss_sync

`default_nettype wire

// file: verilog/mss_top.v
`timescale 1ns/1ps
`default_nettype none
`include "mss_map.vh"

module mss_top
(
    // clock and reset
    input  wire                  mclk,
    input  wire                  rst,
    // register port
    input  wire [`MSS_AW-1:0]    reg_addr,
    input  wire [`MSS_DW-1:0]    reg_wdata,
    input  wire                  reg_wr,
    input  wire                  reg_rd,
    output reg  [`MSS_DW-1:0]    reg_rdata,
    // intelligent input terminals, active high
    input  wire [`MSS_NTERM-1:0] term_in,
    // analog reference from the control terminals
    input  wire [`MSS_DW-1:0]    term_ref,
    // frequency target and state
    output reg  [`MSS_DW-1:0]    freq_target,
    output reg                   override_active,
    output reg  [3:0]            sel_index
);

    // ----------------------------------------
    // functions
    // ----------------------------------------

    // any active terminal carrying function code
    function sel_bit;
        input [`MSS_NTERM*`MSS_FW-1:0] funcs;
        input [`MSS_FW-1:0]            code;
        input [`MSS_NTERM-1:0]         act;
        integer k;
        begin
            sel_bit = 1'b0;
            for (k = 0; k < `MSS_NTERM; k = k + 1)
                if (act[k] && funcs[k*`MSS_FW +: `MSS_FW] == code)
                    sel_bit = 1'b1;
        end
    endfunction

    // limit a frequency to the programmed maximum
    function [`MSS_DW-1:0] clamp;
        input [`MSS_DW-1:0] f;
        input [`MSS_DW-1:0] fmax;
        begin
            clamp = (f > fmax) ? fmax : f;
        end
    endfunction

    // ----------------------------------------
    // storage and state
    // ----------------------------------------
    reg  [1:0]                    freq_source_setting_reg;
    reg  [1:0]                    speed_select_method_reg;
    reg  [`MSS_DW-1:0]            max_frequency_limit_reg;
    reg  [`MSS_DW-1:0]            output_freq_setting_reg;
    reg  [`MSS_DW-1:0]            edit_val_reg;
    reg  [3:0]                    edit_idx_reg;
    reg                           edit_pend_reg;
    reg  [`MSS_NTERM*`MSS_FW-1:0] term_func_reg;

    wire [`MSS_NTERM-1:0]         term_sync;
    wire [`MSS_DW-1:0]            preset_bus;
    wire [`MSS_DW-1:0]            preset_sel;

    reg                           store_fire;
    reg  [3:0]                    idx_next;
    reg                           assigned;
    reg                           override_next;
    reg  [`MSS_DW-1:0]            target_next;
    reg  [`MSS_DW-1:0]            rdata_next;

    // ----------------------------------------
    // terminal synchroniser
    // ----------------------------------------

    // terminals retimed before decoding
    mss_sync u_sync
    (
        .mclk  (mclk),
        .rst   (rst),
        .d_in  (term_in),
        .d_out (term_sync)
    );

    // ----------------------------------------
    // preset table
    // ----------------------------------------

    // bus reads by address, speed path by index
    mss_preset_store u_store
    (
        .mclk    (mclk),
        .rst     (rst),
        .we      (store_fire),
        .widx    (edit_idx_reg),
        .wdata   (edit_val_reg),
        .ridx_a  (reg_addr[3:0]),
        .rdata_a (preset_bus),
        .ridx_b  (idx_next),
        .rdata_b (preset_sel)
    );

    // ----------------------------------------
    // store handshake
    // ----------------------------------------

    // a store with nothing pending is ignored,
    // so a stale edit can never land twice
    // store command with a pending edit commits it
    always @*
    begin
        store_fire = reg_wr && reg_addr == `MSS_A_STORE
                     && reg_wdata[`MSS_STORE_GO]
                     && edit_pend_reg;
    end

    // ----------------------------------------
    // speed decode
    // ----------------------------------------

    // index from function codes, not positions
    // terminals sharing a code are ored together
    always @*
    begin
        idx_next[0] = sel_bit(term_func_reg, `MSS_FN_SEL0,
                              term_sync);
        idx_next[1] = sel_bit(term_func_reg, `MSS_FN_SEL1,
                              term_sync);
        idx_next[2] = sel_bit(term_func_reg, `MSS_FN_SEL2,
                              term_sync);
        idx_next[3] = sel_bit(term_func_reg, `MSS_FN_SEL3,
                              term_sync);
        // unassigned bits never match, so read as zero
        assigned = sel_bit(term_func_reg, `MSS_FN_SEL0, 8'hff)
                 | sel_bit(term_func_reg, `MSS_FN_SEL1, 8'hff)
                 | sel_bit(term_func_reg, `MSS_FN_SEL2, 8'hff)
                 | sel_bit(term_func_reg, `MSS_FN_SEL3, 8'hff);
    end

    // index zero never overrides: all selects off
    // hands the target back to the reference
    // override and target selection
    always @*
    begin
        override_next = (freq_source_setting_reg == `MSS_SRC_TERM)
                     && (speed_select_method_reg == `MSS_METH_BIN)
                     && assigned
                     && (idx_next != 4'h0);
        if (override_next)
            target_next = clamp(preset_sel,
                                max_frequency_limit_reg);
        else if (freq_source_setting_reg == `MSS_SRC_TERM)
            target_next = clamp(term_ref,
                                max_frequency_limit_reg);
        else
            target_next = clamp(output_freq_setting_reg,
                                max_frequency_limit_reg);
    end

    // registered together so no mixed index leaks out
    // index, override and target move in one edge
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sel_index       <= 4'h0;
            override_active <= 1'b0;
            freq_target     <= `MSS_RST_DATA;
        end
        else
        begin
            sel_index       <= idx_next;
            override_active <= override_next;
            freq_target     <= target_next;
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------

    // preset addresses are read only; presets
    // change only through the store path
    // settings, edit buffer and terminal functions
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            freq_source_setting_reg <= `MSS_RST_SOURCE;
            speed_select_method_reg <= `MSS_RST_METHOD;
            max_frequency_limit_reg <= `MSS_RST_MAXFREQ;
            output_freq_setting_reg <= `MSS_RST_OUTSET;
            edit_val_reg            <= `MSS_RST_DATA;
            edit_idx_reg            <= 4'h0;
            edit_pend_reg           <= 1'b0;
            term_func_reg           <= `MSS_RST_TFUNC;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                `MSS_A_SOURCE:
                    freq_source_setting_reg <= reg_wdata[1:0];
                `MSS_A_METHOD:
                    speed_select_method_reg <= reg_wdata[1:0];
                `MSS_A_MAXFREQ:
                    max_frequency_limit_reg <= reg_wdata;
                `MSS_A_OUTSET:
                    output_freq_setting_reg <= reg_wdata;
                `MSS_A_EDITVAL:
                begin
                    // a fresh edit replaces any unstored one
                    edit_val_reg  <= reg_wdata;
                    edit_pend_reg <= 1'b1;
                end
                `MSS_A_EDITIDX:
                begin
                    // moving on drops the unstored edit
                    edit_idx_reg  <= reg_wdata[3:0];
                    edit_pend_reg <= 1'b0;
                end
                `MSS_A_STORE:
                    if (store_fire)
                        edit_pend_reg <= 1'b0;
                default:
                    if (reg_addr[`MSS_AW-1:3] == 3'h4)
                        term_func_reg[reg_addr[2:0]*`MSS_FW
                                      +: `MSS_FW]
                            <= reg_wdata[`MSS_FW-1:0];
            endcase
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------

    // read mux, unmapped reads as zero
    always @*
    begin
        rdata_next = `MSS_RST_DATA;
        case (reg_addr)
            `MSS_A_SOURCE:
                rdata_next[1:0] = freq_source_setting_reg;
            `MSS_A_METHOD:
                rdata_next[1:0] = speed_select_method_reg;
            `MSS_A_MAXFREQ:
                rdata_next = max_frequency_limit_reg;
            `MSS_A_OUTSET:
                rdata_next = output_freq_setting_reg;
            `MSS_A_EDITVAL:
                rdata_next = edit_val_reg;
            `MSS_A_EDITIDX:
                rdata_next[3:0] = edit_idx_reg;
            `MSS_A_STATUS:
            begin
                rdata_next[`MSS_ST_OVR]    = override_active;
                rdata_next[`MSS_ST_ASSIGN] = assigned;
                rdata_next[`MSS_ST_PEND]   = edit_pend_reg;
                rdata_next[`MSS_ST_IDX_LO +: 4] = sel_index;
            end
            `MSS_A_TARGET:
                rdata_next = freq_target;
            default:
                if (reg_addr[`MSS_AW-1:4] == 2'h0)
                    rdata_next = preset_bus;
                else if (reg_addr[`MSS_AW-1:3] == 3'h4)
                    rdata_next[`MSS_FW-1:0] =
                        term_func_reg[reg_addr[2:0]*`MSS_FW
                                      +: `MSS_FW];
                else
                    rdata_next = `MSS_RST_DATA;
        endcase
    end

    // zero outside the read cycle keeps the bus quiet
    // read data one cycle after the strobe, zero otherwise
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= `MSS_RST_DATA;
        else if (reg_rd)
            reg_rdata <= rdata_next;
        else
            reg_rdata <= `MSS_RST_DATA;
    end

endmodule // mss_top

`default_nettype wire
